// ===== common/i2c_port_consts.svh
// Contract
// RQ1 - Master opens each transaction with start; bus is busy from then.
// RQ2 - First byte holds seven address bits then direction bit, 1 read, 0 write.
// RQ3 - Device is selected only when all seven address bits match its own.
// RQ4 - Own address is fixed except lowest bit, which follows the strap pin.
// RQ5 - Addressed receiver pulls data low through the whole acknowledge clock high.
// RQ6 - Master ends each transaction with stop; bus is free afterwards.
// RQ7 - Bytes are eight bits, MSB first, any number per transfer.
// RQ8 - Bus counts as idle when clock and data are both high.
// RQ9 - Write: address byte, register index, then data, each acknowledged and stored.
// RQ10 - Master always sends the register index with its MSB cleared.
// RQ11 - After each acknowledged write data byte the register pointer advances by one.
// RQ12 - Read: index write, repeated start, address with read bit, device returns data.
// RQ13 - Master does not acknowledge its last read byte, then sends stop.
// RQ14 - During reads the device returns consecutive registers while the master acknowledges.
// RQ15 - A target may hold clock low; master waits until it is released.
// RQ16 - Acceleration read stretches clock until conversion done only when stretch bit set.
// RQ17 - Master writes control registers after power-up before relying on the device.
// RQ18 - Chip select high selects two-wire mode; idle device runs factory defaults.
// RQ19 - Enable low means standby, no response; enable rising reloads register defaults.
// RQ20 - On address mismatch release data and ignore everything until next start.
`ifndef I2C_PORT_CONSTS_SVH
`define I2C_PORT_CONSTS_SVH

// Fixed upper six bits of the target address
`define ADDR_FIXED 6'h0c
// Bits per byte, compared with the bit counter
`define BYTE_BITS 4'h8
// Highest register index that holds acceleration data
`define ACCEL_LAST 8'h05
// Direction bit value for a master read
`define DIR_READ 1'b1
// Register pointer after reset
`define PTR_RESET 8'h00
// Depth of the write-data FIFO
`define WR_FIFO_DEPTH 8
// Synchroniser reset: lines high, enable high, chip select high, strap high
`define SYNC_RESET 5'h1f

`endif

// ===== common/i2c_port_pkg.sv
package i2c_port_pkg;

   // Protocol engine states
   typedef enum logic [3:0] {
      ST_IDLE   = 4'h0,
      ST_ADDR   = 4'h1,
      ST_RX     = 4'h2,
      ST_WAIT   = 4'h3,
      ST_ACK    = 4'h4,
      ST_TX     = 4'h5,
      ST_MACK   = 4'h6,
      ST_CONV   = 4'h7,
      ST_IGNORE = 4'h8
   } state_t;

endpackage

// ===== hw/byte_fifo.sv
`timescale 1ns/10ps
module byte_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8,
   parameter int AW    = $clog2(DEPTH)
) (
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output wire logic             in_ready,
   output wire logic             out_valid,
   output wire logic [WIDTH-1:0] out_data,
   input  wire logic             out_ready
);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0]    wr_ptr_ff;
   logic [AW-1:0]    rd_ptr_ff;
   logic [AW:0]      count_ff;
   logic             push;
   logic             pop;

   // Handshake decode
   assign in_ready  = (count_ff != DEPTH[AW:0]);
   assign out_valid = (count_ff != '0);
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   assign out_data  = mem_ff[rd_ptr_ff];

   // Storage, one flop row per entry
   for (genvar i = 0; i < DEPTH; i++) begin : g_entry
      always_ff @(posedge clk or negedge rst_b) begin
         if (!rst_b)
            mem_ff[i] <= '0;
         else if (push && (wr_ptr_ff == AW'(i)))
            mem_ff[i] <= in_data;
      end
   end

   // Pointers and fill level
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff  <= '0;
      end else begin
         wr_ptr_ff <= push ? AW'(wr_ptr_ff + 1'b1) : wr_ptr_ff;
         rd_ptr_ff <= pop ? AW'(rd_ptr_ff + 1'b1) : rd_ptr_ff;
         count_ff  <= (AW+1)'(count_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
      end
   end

endmodule // byte_fifo

// ===== hw/i2c_target_port.sv
`timescale 1ns/10ps
`include "i2c_port_consts.svh"
module i2c_target_port #(
   parameter int FIFO_DEPTH = `WR_FIFO_DEPTH
) (
   input  wire logic                 clk,
   input  wire logic                 rst_b,
   input  wire logic                 scl_i,
   output wire logic                 scl_o,
   output wire logic                 scl_oe,
   input  wire logic                 sda_i,
   output wire logic                 sda_o,
   output wire logic                 sda_oe,
   input  wire logic                 chip_select_n,
   input  wire logic                 enable_i,
   input  wire logic                 addr_strap,
   input  wire logic                 clock_stretch_enable,
   output wire logic                 reload_defaults,
   output wire logic                 conv_start,
   input  wire logic                 conv_done,
   output wire logic [7:0]           rd_addr,
   input  wire logic [7:0]           rd_data,
   output wire logic                 wr_valid,
   input  wire logic                 wr_ready,
   output wire logic [7:0]           wr_addr,
   output wire logic [7:0]           wr_data,
   output wire logic                 bus_busy,
   output i2c_port_pkg::state_t      bus_state
);
   import i2c_port_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   ////////////////////////////////////////////////////////////////////////////

   logic [4:0] sync1_ff;
   logic [4:0] sync2_ff;
   logic       scl_q_ff;
   logic       sda_q_ff;
   logic       en_q_ff;
   logic       scl_s;
   logic       sda_s;
   logic       en_s;
   logic       cs_s;
   logic       strap_s;

   // Two flops on every pin before any use
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sync1_ff <= `SYNC_RESET;
         sync2_ff <= `SYNC_RESET;
      end else begin
         sync1_ff <= {scl_i, sda_i, enable_i, chip_select_n, addr_strap};
         sync2_ff <= sync1_ff;
      end
   end

   assign scl_s   = sync2_ff[4];
   assign sda_s   = sync2_ff[3];
   assign en_s    = sync2_ff[2];
   assign cs_s    = sync2_ff[1];
   assign strap_s = sync2_ff[0];

   // Previous samples for edge finding
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         scl_q_ff <= 1'b1;
         sda_q_ff <= 1'b1;
         en_q_ff  <= 1'b1;
      end else begin
         scl_q_ff <= scl_s;
         sda_q_ff <= sda_s;
         en_q_ff  <= en_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus event decode
   ////////////////////////////////////////////////////////////////////////////

   logic       scl_rise;
   logic       scl_fall;
   logic       start_det;
   logic       stop_det;
   logic       mode_on;
   logic [6:0] own_addr;
   logic       addr_match;
   logic       en_rise;

   state_t     st_ff;
   logic [3:0] bit_cnt_ff;
   logic [7:0] shift_ff;
   logic [7:0] tx_ff;
   logic [7:0] ptr_ff;
   logic       dir_ff;
   logic       idx_seen_ff;
   logic       sda_oe_ff;
   logic       scl_oe_ff;
   logic       busy_ff;
   logic       reload_ff;
   logic       conv_ff;
   logic       byte_done;
   logic       accel_req;
   logic       fifo_ready;
   logic       push;

   assign scl_rise  = scl_s & ~scl_q_ff;
   assign scl_fall  = ~scl_s & scl_q_ff;
   assign start_det = scl_s & scl_q_ff & sda_q_ff & ~sda_s;     // RQ1
   assign stop_det  = scl_s & scl_q_ff & ~sda_q_ff & sda_s;     // RQ6
   assign mode_on   = en_s & cs_s;                              // RQ18 RQ19
   assign own_addr  = {`ADDR_FIXED, strap_s};                   // RQ4
   assign addr_match = (shift_ff[7:1] == own_addr);             // RQ3
   assign en_rise   = en_s & ~en_q_ff;                          // RQ19
   assign byte_done = (bit_cnt_ff == `BYTE_BITS);               // RQ7
   assign accel_req = clock_stretch_enable & (ptr_ff <= `ACCEL_LAST); // RQ16

   ////////////////////////////////////////////////////////////////////////////
   // Protocol engine
   ////////////////////////////////////////////////////////////////////////////

   state_t     nxt_st;
   logic [3:0] nxt_bit_cnt;
   logic [7:0] nxt_shift;
   logic [7:0] nxt_tx;
   logic [7:0] nxt_ptr;
   logic       nxt_dir;
   logic       nxt_idx_seen;
   logic       nxt_sda_oe;
   logic       nxt_scl_oe;
   logic       nxt_busy;
   logic       nxt_conv;

   // Next-state decode, driven by sampled bus edges
   always_comb begin
      nxt_st       = st_ff;
      nxt_bit_cnt  = bit_cnt_ff;
      nxt_shift    = shift_ff;
      nxt_tx       = tx_ff;
      nxt_ptr      = ptr_ff;
      nxt_dir      = dir_ff;
      nxt_idx_seen = idx_seen_ff;
      nxt_sda_oe   = sda_oe_ff;
      nxt_scl_oe   = scl_oe_ff;
      nxt_busy     = busy_ff;
      nxt_conv     = 1'b0;
      push         = 1'b0;
      if (!mode_on) begin // RQ19
         nxt_st     = ST_IDLE;
         nxt_sda_oe = 1'b0;
         nxt_scl_oe = 1'b0;
         nxt_busy   = 1'b0;
      end else if (stop_det) begin // RQ8
         nxt_st     = ST_IDLE;
         nxt_sda_oe = 1'b0;
         nxt_scl_oe = 1'b0;
         nxt_busy   = 1'b0;
      end else if (start_det) begin // RQ1
         nxt_st       = ST_ADDR;
         nxt_bit_cnt  = 4'h0;
         nxt_idx_seen = 1'b0;
         nxt_sda_oe   = 1'b0;
         nxt_scl_oe   = 1'b0;
         nxt_busy     = 1'b1;
      end else begin
         case (st_ff)
            ST_ADDR: begin
               if (scl_rise) begin // RQ7
                  nxt_shift   = {shift_ff[6:0], sda_s};
                  nxt_bit_cnt = 4'(bit_cnt_ff + 1'b1);
               end else if (scl_fall && byte_done) begin
                  nxt_bit_cnt = 4'h0;
                  if (addr_match) begin // RQ3
                     nxt_dir    = shift_ff[0]; // RQ2
                     nxt_st     = ST_ACK;
                     nxt_sda_oe = 1'b1; // RQ5
                  end else begin
                     nxt_st = ST_IGNORE; // RQ20
                  end
               end
            end
            ST_RX: begin
               if (scl_rise) begin
                  nxt_shift   = {shift_ff[6:0], sda_s};
                  nxt_bit_cnt = 4'(bit_cnt_ff + 1'b1);
               end else if (scl_fall && byte_done) begin
                  nxt_bit_cnt = 4'h0;
                  if (!idx_seen_ff) begin // RQ9 RQ10
                     nxt_ptr      = shift_ff;
                     nxt_idx_seen = 1'b1;
                     nxt_st       = ST_ACK;
                     nxt_sda_oe   = 1'b1;
                  end else if (fifo_ready) begin // RQ9
                     push       = 1'b1;
                     nxt_ptr    = 8'(ptr_ff + 1'b1); // RQ11
                     nxt_st     = ST_ACK;
                     nxt_sda_oe = 1'b1;
                  end else begin
                     nxt_st     = ST_WAIT;
                     nxt_scl_oe = 1'b1; // RQ15
                  end
               end
            end
            ST_WAIT: begin
               if (fifo_ready) begin
                  push       = 1'b1;
                  nxt_ptr    = 8'(ptr_ff + 1'b1); // RQ11
                  nxt_st     = ST_ACK;
                  nxt_sda_oe = 1'b1;
                  nxt_scl_oe = 1'b0;
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  nxt_sda_oe  = 1'b0;
                  nxt_bit_cnt = 4'h0;
                  if (dir_ff == `DIR_READ) begin // RQ12
                     if (accel_req) begin // RQ16
                        nxt_st     = ST_CONV;
                        nxt_scl_oe = 1'b1;
                        nxt_conv   = 1'b1;
                     end else begin
                        nxt_st     = ST_TX;
                        nxt_tx     = rd_data;
                        nxt_sda_oe = ~rd_data[7];
                        nxt_ptr    = 8'(ptr_ff + 1'b1);
                     end
                  end else begin
                     nxt_st = ST_RX;
                  end
               end
            end
            ST_CONV: begin
               if (conv_done) begin // RQ16
                  nxt_st     = ST_TX;
                  nxt_scl_oe = 1'b0;
                  nxt_tx     = rd_data;
                  nxt_sda_oe = ~rd_data[7];
                  nxt_ptr    = 8'(ptr_ff + 1'b1);
               end
            end
            ST_TX: begin
               if (scl_rise) begin
                  nxt_bit_cnt = 4'(bit_cnt_ff + 1'b1);
               end else if (scl_fall) begin
                  if (byte_done) begin
                     nxt_bit_cnt = 4'h0;
                     nxt_sda_oe  = 1'b0;
                     nxt_st      = ST_MACK;
                  end else begin // RQ7
                     nxt_tx     = {tx_ff[6:0], 1'b0};
                     nxt_sda_oe = ~tx_ff[6];
                  end
               end
            end
            ST_MACK: begin
               if (scl_rise && sda_s) begin // RQ13
                  nxt_st = ST_IGNORE;
               end else if (scl_fall) begin // RQ14
                  nxt_st     = ST_TX;
                  nxt_tx     = rd_data;
                  nxt_sda_oe = ~rd_data[7];
                  nxt_ptr    = 8'(ptr_ff + 1'b1);
               end
            end
            ST_IDLE, ST_IGNORE: begin // RQ20
               nxt_sda_oe = 1'b0;
               nxt_scl_oe = 1'b0;
            end
            default: begin
               nxt_st     = ST_IDLE;
               nxt_sda_oe = 1'b0;
               nxt_scl_oe = 1'b0;
            end
         endcase
      end
   end

   // Engine state
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_ff       <= ST_IDLE;
         bit_cnt_ff  <= 4'h0;
         shift_ff    <= 8'h00;
         tx_ff       <= 8'h00;
         dir_ff      <= 1'b0;
         idx_seen_ff <= 1'b0;
      end else begin
         st_ff       <= nxt_st;
         bit_cnt_ff  <= nxt_bit_cnt;
         shift_ff    <= nxt_shift;
         tx_ff       <= nxt_tx;
         dir_ff      <= nxt_dir;
         idx_seen_ff <= nxt_idx_seen;
      end
   end

   // Pointer survives repeated start; defaults reload resets it
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b)
         ptr_ff <= `PTR_RESET;
      else if (en_rise)
         ptr_ff <= `PTR_RESET;
      else
         ptr_ff <= nxt_ptr;
   end

   // Pin drives and pulses
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sda_oe_ff <= 1'b0;
         scl_oe_ff <= 1'b0;
         busy_ff   <= 1'b0;
         reload_ff <= 1'b0;
         conv_ff   <= 1'b0;
      end else begin
         sda_oe_ff <= nxt_sda_oe;
         scl_oe_ff <= nxt_scl_oe;
         busy_ff   <= nxt_busy;
         reload_ff <= en_rise; // RQ19
         conv_ff   <= nxt_conv;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Write data buffer
   ////////////////////////////////////////////////////////////////////////////

   logic [15:0] fifo_out;

   // Each written byte leaves with its register index
   byte_fifo #(
      .WIDTH (16),
      .DEPTH (FIFO_DEPTH)
   ) u_wr_fifo (
      .clk       (clk),
      .rst_b     (rst_b),
      .in_valid  (push),
      .in_data   ({ptr_ff, shift_ff}),
      .in_ready  (fifo_ready),
      .out_valid (wr_valid),
      .out_data  (fifo_out),
      .out_ready (wr_ready)
   );

   // Outputs
   assign wr_addr         = fifo_out[15:8];
   assign wr_data         = fifo_out[7:0];
   assign rd_addr         = ptr_ff;
   assign scl_o           = 1'b0;
   assign sda_o           = 1'b0;
   assign scl_oe          = scl_oe_ff;
   assign sda_oe          = sda_oe_ff;
   assign bus_busy        = busy_ff;
   assign bus_state       = st_ff;
   assign reload_defaults = reload_ff;
   assign conv_start      = conv_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   ////////////////////////////////////////////////////////////////////////////

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   sequence addr_byte_end;
      mode_on && !start_det && !stop_det && st_ff == ST_ADDR && scl_fall && byte_done;
   endsequence

   sequence quiet_cycle;
      mode_on && !start_det && !stop_det;
   endsequence

   addr_hit_a: assert property (addr_byte_end and addr_match |=> sda_oe_ff && st_ff == ST_ACK) // RQ3
      else $error("matching address not acknowledged");
   addr_miss_a: assert property (addr_byte_end and !addr_match |=> !sda_oe_ff && st_ff == ST_IGNORE) // RQ20
      else $error("foreign address not ignored");
   ignore_quiet_a: assert property (st_ff == ST_IGNORE |-> !sda_oe_ff && !scl_oe_ff) // RQ20
      else $error("lines driven while ignoring");
   ack_hold_a: assert property ((st_ff == ST_ACK && !scl_fall) and quiet_cycle |=> sda_oe_ff) // RQ5
      else $error("acknowledge released early");
   standby_a: assert property (!mode_on |=> st_ff == ST_IDLE && !sda_oe_ff && !scl_oe_ff) // RQ19
      else $error("active in standby");
   reload_pulse_a: assert property (en_rise |=> reload_defaults ##1 !reload_defaults) // RQ19
      else $error("defaults reload pulse wrong");
   start_seen_a: assert property (mode_on && start_det |=> st_ff == ST_ADDR && bit_cnt_ff == 4'h0 && bus_busy) // RQ1
      else $error("start not taken");
   stop_seen_a: assert property (mode_on && stop_det |=> st_ff == ST_IDLE && !bus_busy) // RQ8
      else $error("stop not taken");
   ptr_step_a: assert property (push && !en_rise |=> ptr_ff == 8'($past(ptr_ff) + 1'b1)) // RQ11
      else $error("pointer did not advance");
   stretch_hold_a: assert property ((st_ff == ST_CONV && !conv_done) and quiet_cycle |=> scl_oe_ff) // RQ16
      else $error("clock not held during conversion");
   no_stretch_a: assert property ($rose(st_ff == ST_CONV) |-> $past(clock_stretch_enable) && conv_start) // RQ16
      else $error("conversion stretch without enable");

endmodule // i2c_target_port

// ===== verif/i2c_master_model.sv
`timescale 1ns/10ps
// Bus master on the far side of the two-wire link, open drain on both lines
module i2c_master_model (
   input  wire logic clk,
   input  wire logic scl_w,
   input  wire logic sda_w,
   output logic      scl_low,
   output logic      sda_low
);
   int hang;

   // Lines released at time zero
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
      hang    = 0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Advance n cycles, landing just after the edge
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // One clock pulse: data set mid-low, sampled late in the high phase
   task automatic pulse(input logic b, output logic r);
      int k;
      k = 0;
      step(2);
      sda_low = ~b;
      step(2);
      scl_low = 1'b0;
      while (!scl_w && k < 2000) begin
         step(1);
         k++;
      end
      if (k >= 2000) hang++;
      step(3);
      r = sda_w;
      step(1);
      scl_low = 1'b1;
   endtask

   // Start or repeated start: data falls while clock high
   task automatic start();
      step(2);
      sda_low = 1'b0;
      step(2);
      scl_low = 1'b0;
      step(4);
      sda_low = 1'b1;
      step(4);
      scl_low = 1'b1;
   endtask

   // Stop: data rises while clock high, both lines left released
   task automatic stop();
      step(2);
      sda_low = 1'b1;
      step(2);
      scl_low = 1'b0;
      step(4);
      sda_low = 1'b0;
      step(4);
   endtask

   // Byte out MSB first, then release data for the target's answer
   task automatic send(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) pulse(d[i], r);
      pulse(1'b1, r);
      ack = ~r;
   endtask

   // Byte in MSB first; last byte is left unacknowledged
   task automatic recv(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         pulse(1'b1, r);
         d[i] = r;
      end
      pulse(last, r);
   endtask
endmodule // i2c_master_model

// ===== verif/test_i2c_target_port.sv
`timescale 1ns/10ps
module test_i2c_target_port;
   import i2c_port_pkg::*;
   logic            clk, rst_b, cs_n, en, strap, str_en, conv_done, drain;
   wire logic       scl_w, sda_w, scl_low, sda_low, scl_oe, sda_oe;
   wire logic       reload, conv_start, wr_valid, busy, scl_o_w, sda_o_w;
   wire logic [7:0] rd_addr, wr_addr, wr_data, rd_data;
   state_t          st;
   int              n_fail, num_checks, n_conv, n_hold, n_drive, n_reload, conv_wait;
   logic [15:0]     got_q[$];

   // Register file model answers from the pointer
   assign rd_data = rd_addr ^ 8'h5a;

   // Open-drain lines with pull-ups
   assign scl_w = ~(scl_low | scl_oe);
   assign sda_w = ~(sda_low | sda_oe);

   i2c_target_port DUT (
      .clk(clk), .rst_b(rst_b), .scl_i(scl_w), .scl_o(scl_o_w), .scl_oe(scl_oe),
      .sda_i(sda_w), .sda_o(sda_o_w), .sda_oe(sda_oe), .chip_select_n(cs_n), .enable_i(en),
      .addr_strap(strap), .clock_stretch_enable(str_en), .reload_defaults(reload),
      .conv_start(conv_start), .conv_done(conv_done), .rd_addr(rd_addr), .rd_data(rd_data),
      .wr_valid(wr_valid), .wr_ready(drain), .wr_addr(wr_addr), .wr_data(wr_data),
      .bus_busy(busy), .bus_state(st));

   i2c_master_model mst (.clk(clk), .scl_w(scl_w), .sda_w(sda_w), .scl_low(scl_low), .sda_low(sda_low));

   always #25 clk = ~clk;

   // Converter answers 20 cycles after each request
   always @(posedge clk) begin
      #1;
      conv_done = (conv_wait == 1);
      if (conv_start) conv_wait = 20;
      else if (conv_wait > 0) conv_wait--;
   end

   // Write consumer and event counters, sampled mid-cycle
   always @(negedge clk) begin
      if (wr_valid && drain) got_q.push_back({wr_addr, wr_data});
      n_conv   += int'(conv_start);
      n_hold   += int'(scl_oe);
      n_drive  += int'(sda_oe);
      n_reload += int'(reload);
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // Write transfer; every answer compared against the expected acknowledge
   task automatic wr_xfer(input logic [6:0] a, input logic [7:0] idx, input int n, input logic [7:0] d0,
                          input logic exp);
      logic ack;
      mst.start();
      mst.send({a, 1'b0}, ack);
      check("address ack", 16'(exp), 16'(ack));
      mst.send(idx, ack);
      check("index ack", 16'(exp), 16'(ack));
      for (int i = 0; i < n; i++) begin
         mst.send(8'(d0 + i), ack);
         check("data ack", 16'(exp), 16'(ack));
      end
      mst.stop();
      mst.step(12);
   endtask

   // Index write, repeated start, then n reads from consecutive registers
   task automatic rd_xfer(input logic [7:0] idx, input int n);
      logic       ack;
      logic [7:0] d;
      mst.start();
      mst.send(8'h30, ack);
      mst.send(idx, ack);
      mst.start();
      mst.send(8'h31, ack);
      check("read address ack", 16'h1, 16'(ack));
      for (int i = 0; i < n; i++) begin
         mst.recv(i == n - 1, d);
         check("read data", 16'(8'(idx + i) ^ 8'h5a), 16'(d));
      end
      mst.stop();
      mst.step(12);
   endtask

   // Drained queue must hold consecutive indices with the sent data
   task automatic expect_q(input logic [7:0] idx, input logic [7:0] d0, input int n);
      check("write count", 16'(n), 16'(got_q.size()));
      for (int i = 0; i < n && got_q.size() > 0; i++)
         check("write word", {8'(idx + i), 8'(d0 + i)}, got_q.pop_front());
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_write();
      mst.start();
      mst.step(4);
      check("busy after start", 16'h1, 16'(busy));
      check("state after start", 16'(ST_ADDR), 16'(st));
      mst.stop();
      mst.step(6);
      check("busy after stop", 16'h0, 16'(busy));
      check("state after stop", 16'(ST_IDLE), 16'(st));
      wr_xfer(7'h18, 8'h0c, 3, 8'ha0, 1'b1);
      expect_q(8'h0c, 8'ha0, 3);
   endtask

   task automatic t_fifo_full();
      n_hold = 0;
      drain  = 1'b0;
      fork
         wr_xfer(7'h18, 8'h10, 9, 8'h30, 1'b1);
         begin
            wait (n_hold > 0);
            mst.step(50);
            drain = 1'b1;
         end
      join
      check("held for full buffer", 16'h1, 16'(n_hold >= 45));
      expect_q(8'h10, 8'h30, 9);
   endtask

   task automatic t_reads();
      str_en = 1'b0;
      n_conv = 0;
      n_hold = 0;
      rd_xfer(8'h02, 3);
      check("no conversion", 16'h0, 16'(n_conv + n_hold));
      str_en = 1'b1;
      rd_xfer(8'h00, 2);
      check("one conversion", 16'h1, 16'(n_conv));
      check("held for conversion", 16'h1, 16'(n_hold >= 20));
      str_en = 1'b0;
   endtask

   task automatic t_address();
      strap = 1'b1;
      mst.step(6);
      n_drive = 0;
      wr_xfer(7'h18, 8'h08, 1, 8'h11, 1'b0);
      for (int i = 1; i < 7; i++) wr_xfer(7'h19 ^ 7'(1 << i), 8'h08, 1, 8'h11, 1'b0);
      check("data line untouched", 16'h0, 16'(n_drive));
      wr_xfer(7'h19, 8'h08, 1, 8'h11, 1'b1);
      expect_q(8'h08, 8'h11, 1);
   endtask

   task automatic t_standby();
      n_reload = 0;
      en = 1'b0;
      mst.step(8);
      wr_xfer(7'h19, 8'h08, 1, 8'h22, 1'b0);
      en = 1'b1;
      mst.step(10);
      check("reload pulse", 16'h1, 16'(n_reload));
      cs_n = 1'b0;
      mst.step(8);
      wr_xfer(7'h19, 8'h08, 1, 8'h22, 1'b0);
      cs_n = 1'b1;
      mst.step(8);
      check("nothing stored", 16'h0, 16'(got_q.size()));
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk       = 1'b0;
      rst_b     = 1'b0;
      strap     = 1'b0;
      str_en    = 1'b0;
      conv_done = 1'b0;
      cs_n      = 1'b1;
      en        = 1'b1;
      drain     = 1'b1;
      repeat (2) @(posedge clk);
      #1 rst_b = 1'b1;
      mst.step(6);
      t_write();
      t_fifo_full();
      t_reads();
      t_address();
      t_standby();
      check("master stalls", 16'h0, 16'(mst.hang));
      check("open drain values", 16'h0, 16'({scl_o_w, sda_o_w}));
      print_verdict();
   end

   // Watchdog well beyond the expected run of some 4800 cycles
   initial begin
      #1000000;
      n_fail++;
      print_verdict();
   end
endmodule // test_i2c_target_port
